// file: src/power_mode_controller.sv
`timescale 1ns/1ps
module power_mode_controller (
  input  wire logic                          clk_sys_i,
  input  wire logic                          rst_b_i,
  input  wire logic                          reset_pin_i,
  input  wire logic                          rtc_irq_i,
  input  wire logic                          wake_i,
  input  wire logic                          pll_wr_i,
  input  wire logic [pmc_pkg::PLL_CONTROL_REG_W-1:0] pll_wdata_i,
  input  wire logic                          vr_wr_i,
  input  wire logic [pmc_pkg::REGULATOR_CONTROL_REG_W-1:0]  vr_wdata_i,
  input  wire pmc_pkg::req_t                 mode_req_i,
  input  wire logic                          dma_l1_req_i,
  input  wire logic                          dma_l1_cfg_ok_i,
  input  wire logic                          async_acc_req_i,
  input  wire logic [pmc_pkg::PIN_W-1:0]     pin_oe_i,
  input  wire logic [pmc_pkg::PIN_W-1:0]     pin_keep_i,
  output logic [pmc_pkg::PLL_CONTROL_REG_W-1:0]      pll_control_reg_o,
  output logic [pmc_pkg::REGULATOR_CONTROL_REG_W-1:0]       regulator_control_reg_o,
  output pmc_pkg::pmode_t                    mode_o,
  output logic                               pll_en_o,
  output logic                               pll_bypass_o,
  output logic                               core_clk_en_o,
  output logic                               sys_clk_en_o,
  output logic                               regulator_on_o,
  output logic                               dma_l1_gnt_o,
  output logic                               async_acc_gnt_o,
  output logic                               req_refused_o,
  output logic [pmc_pkg::PIN_W-1:0]          pin_oe_o
);
  pmc_sw_if sw ();
  assign sw.pll_wr    = pll_wr_i;
  assign sw.pll_wdata = pll_wdata_i;
  assign sw.vr_wr     = vr_wr_i;
  assign sw.vr_wdata  = vr_wdata_i;

  pmc_ctl_regs u_regs (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .sw        (sw)
  );

  // pin synchronisers
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
    end else begin
      sync1_r <= {reset_pin_i, rtc_irq_i, wake_i};
      sync2_r <= sync1_r;
    end
  end

  wire rst_pin_s = sync2_r[2];
  wire rtc_s     = sync2_r[1];
  wire wake_s    = sync2_r[0];

  wire pll_off    = sw.pll_q[pmc_pkg::PLL_OFF_BIT];
  wire pll_bypass = sw.pll_q[pmc_pkg::PLL_BYP_BIT];
  wire [1:0] vr_regulator_field_a = sw.vr_q[pmc_pkg::VR_REGULATOR_FIELD_A_LO +: 2];
  wire hib_cmd    = vr_wr_i &&
                    vr_wdata_i[pmc_pkg::VR_REGULATOR_FIELD_A_LO +: 2] ==
                    pmc_pkg::VR_REGULATOR_FIELD_A_OFF;

  pmc_pkg::pmode_t mode_r;
  pmc_pkg::pmode_t mode_nxt;
  logic            refused_r;
  logic            refused_nxt;

  wire want_fast = mode_req_i == pmc_pkg::REQ_FULL_ON ||
                   mode_req_i == pmc_pkg::REQ_SLEEP;
  wire refuse    = mode_r == pmc_pkg::ACTIVE && want_fast && pll_off;

  // a regulator-off write wins over any pending mode request
  always_comb begin
    mode_nxt    = mode_r;
    refused_nxt = 1'b0;
    unique case (mode_r)
      pmc_pkg::FULL_ON, pmc_pkg::ACTIVE: begin
        if (hib_cmd) begin
          mode_nxt = pmc_pkg::HIBERNATE;
        end else if (refuse) begin
          refused_nxt = 1'b1;
        end else if (mode_req_i == pmc_pkg::REQ_SLEEP) begin
          mode_nxt = pmc_pkg::SLEEP;
        end else if (mode_req_i == pmc_pkg::REQ_DEEP_SLEEP) begin
          mode_nxt = pmc_pkg::DEEP_SLEEP;
        end else if (mode_req_i == pmc_pkg::REQ_FULL_ON &&
                     !pll_bypass) begin
          mode_nxt = pmc_pkg::FULL_ON;
        end else if (mode_r == pmc_pkg::FULL_ON && pll_bypass) begin
          mode_nxt = pmc_pkg::ACTIVE;
        end
      end
      pmc_pkg::SLEEP: begin
        if (wake_s || rtc_s) begin
          mode_nxt = pll_bypass ? pmc_pkg::ACTIVE : pmc_pkg::FULL_ON;
        end
      end
      pmc_pkg::DEEP_SLEEP: begin
        if (rst_pin_s) begin
          mode_nxt = pmc_pkg::FULL_ON;
        end else if (rtc_s) begin
          mode_nxt = pmc_pkg::ACTIVE;
        end
      end
      pmc_pkg::HIBERNATE: begin
        if (rst_pin_s || rtc_s) begin
          mode_nxt = pmc_pkg::FULL_ON;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode_r    <= pmc_pkg::FULL_ON;
      refused_r <= 1'b0;
    end else begin
      mode_r    <= mode_nxt;
      refused_r <= refused_nxt;
    end
  end

  wire in_full  = mode_r == pmc_pkg::FULL_ON;
  wire in_act   = mode_r == pmc_pkg::ACTIVE;
  wire in_sleep = mode_r == pmc_pkg::SLEEP;
  wire in_hib   = mode_r == pmc_pkg::HIBERNATE;
  wire in_deep  = mode_r == pmc_pkg::DEEP_SLEEP;

  // clock, supply, grant and pin controls decoded from the mode
  assign mode_o          = mode_r;
  assign pll_control_reg_o       = sw.pll_q;
  assign regulator_control_reg_o        = sw.vr_q;
  assign req_refused_o   = refused_r;
  assign pll_en_o        = in_full || in_sleep ||
                           (in_act && !pll_off);
  assign pll_bypass_o    = in_act;
  assign core_clk_en_o   = in_full || in_act;
  assign sys_clk_en_o    = in_full || in_act || in_sleep;
  assign regulator_on_o  = !in_hib;
  assign dma_l1_gnt_o    = dma_l1_req_i && dma_l1_cfg_ok_i &&
                           (in_act || in_full);
  assign async_acc_gnt_o = async_acc_req_i && (in_full || in_act);
  assign pin_oe_o        = in_hib ? (pin_oe_i & pin_keep_i)
                                  : pin_oe_i;

  // hibernate is only reached through a regulator-off write
  unused_vr_regulator_field_a_a: assert property (@(posedge clk_sys_i)
    disable iff (!rst_b_i) in_hib |-> vr_regulator_field_a == pmc_pkg::VR_REGULATOR_FIELD_A_OFF ||
    $past(in_hib))
    else $error("hibernate without regulator command");

  hib_entry_a: assert property (@(posedge clk_sys_i)
    disable iff (!rst_b_i) ((in_full || in_act) && hib_cmd) |=> in_hib)
    else $error("regulator-off write did not hibernate");

  act_clocks_a: assert property (@(posedge clk_sys_i)
    disable iff (!rst_b_i) in_act |-> pll_bypass_o && core_clk_en_o &&
    sys_clk_en_o)
    else $error("active clocks wrong");

  act_pll_a: assert property (@(posedge clk_sys_i)
    disable iff (!rst_b_i) in_act |-> pll_en_o == !pll_off)
    else $error("active pll enable wrong");

  act_dma_a: assert property (@(posedge clk_sys_i)
    disable iff (!rst_b_i) (in_act && dma_l1_req_i && dma_l1_cfg_ok_i) |->
    dma_l1_gnt_o)
    else $error("active dma not granted");

  full_pll_a: assert property (@(posedge clk_sys_i)
    disable iff (!rst_b_i) in_full |-> pll_en_o && !pll_bypass_o)
    else $error("full-on pll wrong");

  sleep_clk_a: assert property (@(posedge clk_sys_i)
    disable iff (!rst_b_i) in_sleep |-> !core_clk_en_o && sys_clk_en_o &&
    pll_en_o && !dma_l1_gnt_o)
    else $error("sleep clocks or dma wrong");

  refuse_hold_a: assert property (@(posedge clk_sys_i)
    disable iff (!rst_b_i) (in_act && pll_off && want_fast && !hib_cmd)
    |=> in_act && req_refused_o)
    else $error("refused request moved mode");

  // wake target follows the bypass bit seen on the wake edge
  sleep_wake_a: assert property (@(posedge clk_sys_i)
    disable iff (!rst_b_i) (in_sleep && wake_s) |=>
    mode_r == ($past(pll_bypass) ? pmc_pkg::ACTIVE : pmc_pkg::FULL_ON))
    else $error("sleep wake target wrong");

  deep_gate_a: assert property (@(posedge clk_sys_i)
    disable iff (!rst_b_i) in_deep |-> !core_clk_en_o && !sys_clk_en_o &&
    !async_acc_gnt_o && !dma_l1_gnt_o)
    else $error("deep sleep gating wrong");

  deep_exit_a: assert property (@(posedge clk_sys_i)
    disable iff (!rst_b_i) (mode_r == pmc_pkg::DEEP_SLEEP && !rst_pin_s &&
    !rtc_s) |=> mode_r == pmc_pkg::DEEP_SLEEP)
    else $error("deep sleep left without cause");

  deep_rtc_a: assert property (@(posedge clk_sys_i)
    disable iff (!rst_b_i) (mode_r == pmc_pkg::DEEP_SLEEP && rtc_s &&
    !rst_pin_s) |=> in_act)
    else $error("rtc from deep sleep not active");

  deep_rst_a: assert property (@(posedge clk_sys_i)
    disable iff (!rst_b_i) (mode_r == pmc_pkg::DEEP_SLEEP && rst_pin_s)
    |=> in_full)
    else $error("reset from deep sleep not full-on");

  // kept pins alone may stay driven while the core supply is off
  hib_pins_a: assert property (@(posedge clk_sys_i)
    disable iff (!rst_b_i) in_hib |-> !regulator_on_o && !sys_clk_en_o &&
    (pin_oe_o & ~pin_keep_i) == '0)
    else $error("hibernate outputs wrong");

  hib_wake_a: assert property (@(posedge clk_sys_i)
    disable iff (!rst_b_i) (in_hib && (rst_pin_s || rtc_s)) |=>
    regulator_on_o)
    else $error("regulator not restarted");
endmodule

// file: src/pmc_pkg.sv
// Notes on behaviour
// - active: pll on but bypassed, core and system clocks at input rate
// - active: dma into suitably configured l1 memories is granted
// - pll off allowed in active; full-on or sleep refused until re-enabled
// - sleep: core clock stopped, pll and system clock keep running
// - wake from sleep: bypass clear gives full-on, bypass set gives active
// - sleep: system dma requests to l1 are not granted
// - deep sleep: core clock and synchronous peripheral clock stopped
// - deep sleep: async peripherals blocked from internal and external
// - deep sleep left only by reset or rtc interrupt
// - rtc interrupt in deep sleep moves to active
// - reset in deep sleep moves to full-on
// - regulator field written 00 in full-on or active shuts regulator, removes clocks, hibernate
// - hibernate: external pins three-stated except those kept
// - hibernate left on rtc wakeup or reset pin, regulator restarts
package pmc_pkg;
  typedef enum logic [2:0] {
    FULL_ON,
    ACTIVE,
    SLEEP,
    DEEP_SLEEP,
    HIBERNATE
  } pmode_t;

  typedef enum logic [1:0] {
    REQ_NONE,
    REQ_FULL_ON,
    REQ_SLEEP,
    REQ_DEEP_SLEEP
  } req_t;

  localparam int          PLL_CONTROL_REG_W     = 16;
  localparam int          PLL_BYP_BIT   = 8;
  localparam int          PLL_OFF_BIT   = 1;
  localparam logic [15:0] PLL_CONTROL_REG_RST   = 16'h0000;
  localparam int          REGULATOR_CONTROL_REG_W      = 16;
  localparam int          VR_REGULATOR_FIELD_A_LO    = 0;
  localparam logic [1:0]  VR_REGULATOR_FIELD_A_OFF   = 2'h0;
  localparam logic [15:0] REGULATOR_CONTROL_REG_RST    = 16'h0003;
  localparam int          PIN_W         = 8;
endpackage

// file: src/pmc_sw_if.sv
`timescale 1ns/1ps
interface pmc_sw_if;
  logic                               pll_wr;
  logic [pmc_pkg::PLL_CONTROL_REG_W-1:0]      pll_wdata;
  logic                               vr_wr;
  logic [pmc_pkg::REGULATOR_CONTROL_REG_W-1:0]       vr_wdata;
  logic [pmc_pkg::PLL_CONTROL_REG_W-1:0]      pll_q;
  logic [pmc_pkg::REGULATOR_CONTROL_REG_W-1:0]       vr_q;
  modport ctl (input pll_wr, pll_wdata, vr_wr, vr_wdata,
               output pll_q, vr_q);
  modport src (output pll_wr, pll_wdata, vr_wr, vr_wdata,
               input pll_q, vr_q);
endinterface

// file: src/pmc_ctl_regs.sv
`timescale 1ns/1ps
module pmc_ctl_regs (
  input  wire logic clk_sys_i,
  input  wire logic rst_b_i,
  pmc_sw_if.ctl     sw
);
  logic [pmc_pkg::PLL_CONTROL_REG_W-1:0] pll_r;
  logic [pmc_pkg::REGULATOR_CONTROL_REG_W-1:0]  vr_r;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pll_r <= pmc_pkg::PLL_CONTROL_REG_RST;
      vr_r  <= pmc_pkg::REGULATOR_CONTROL_REG_RST;
    end else begin
      if (sw.pll_wr) begin
        pll_r <= sw.pll_wdata;
      end
      if (sw.vr_wr) begin
        vr_r <= sw.vr_wdata;
      end
    end
  end

  assign sw.pll_q = pll_r;
  assign sw.vr_q  = vr_r;
endmodule

// file: tb/tb_power_mode_controller.sv
`timescale 1ns/1ps
module tb_power_mode_controller;
  logic                          clk_sys_i, rst_b_i;
  logic                          reset_pin_i, rtc_irq_i, wake_i;
  logic                          pll_wr_i, vr_wr_i;
  logic [pmc_pkg::PLL_CONTROL_REG_W-1:0] pll_wdata_i, pll_control_reg_o;
  logic [pmc_pkg::REGULATOR_CONTROL_REG_W-1:0]  vr_wdata_i, regulator_control_reg_o;
  pmc_pkg::req_t                 mode_req_i;
  pmc_pkg::pmode_t               mode_o;
  logic                          dma_l1_req_i, dma_l1_cfg_ok_i;
  logic                          async_acc_req_i;
  logic [pmc_pkg::PIN_W-1:0]     pin_oe_i, pin_keep_i, pin_oe_o;
  logic                          pll_en_o, pll_bypass_o, core_clk_en_o;
  logic                          sys_clk_en_o, regulator_on_o;
  logic                          dma_l1_gnt_o, async_acc_gnt_o, req_refused_o;
  int                            error_cnt = 0;
  int                            checks = 0;

  power_mode_controller power_mode_controller_inst (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .reset_pin_i(reset_pin_i),
    .rtc_irq_i(rtc_irq_i), .wake_i(wake_i), .pll_wr_i(pll_wr_i),
    .pll_wdata_i(pll_wdata_i), .vr_wr_i(vr_wr_i), .vr_wdata_i(vr_wdata_i),
    .mode_req_i(mode_req_i), .dma_l1_req_i(dma_l1_req_i),
    .dma_l1_cfg_ok_i(dma_l1_cfg_ok_i), .async_acc_req_i(async_acc_req_i),
    .pin_oe_i(pin_oe_i), .pin_keep_i(pin_keep_i), .pll_control_reg_o(pll_control_reg_o),
    .regulator_control_reg_o(regulator_control_reg_o), .mode_o(mode_o), .pll_en_o(pll_en_o),
    .pll_bypass_o(pll_bypass_o), .core_clk_en_o(core_clk_en_o),
    .sys_clk_en_o(sys_clk_en_o), .regulator_on_o(regulator_on_o),
    .dma_l1_gnt_o(dma_l1_gnt_o), .async_acc_gnt_o(async_acc_gnt_o),
    .req_refused_o(req_refused_o), .pin_oe_o(pin_oe_o)
  );

  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n = 1);
    repeat (n) @(negedge clk_sys_i);
  endtask

  // bounded wait, then compare the mode
  task automatic wait_mode(input pmc_pkg::pmode_t m);
    for (int i = 0; i < 10 && mode_o !== m; i++) cyc();
    chk("mode_o", 16'(mode_o), 16'(m));
  endtask

  // order: pll_en, bypass, core clk, sys clk, regulator
  task automatic chk_clk(input logic [4:0] exp);
    chk("clock_ctl", {11'h000, pll_en_o, pll_bypass_o, core_clk_en_o,
        sys_clk_en_o, regulator_on_o}, {11'h000, exp});
  endtask

  task automatic wr(input logic to_vr, input logic [15:0] d);
    pll_wr_i = ~to_vr;
    vr_wr_i = to_vr;
    pll_wdata_i = d;
    vr_wdata_i = d;
    cyc();
    pll_wr_i = 1'b0;
    vr_wr_i = 1'b0;
  endtask

  task automatic req(input pmc_pkg::req_t r);
    mode_req_i = r;
    cyc();
    mode_req_i = pmc_pkg::REQ_NONE;
  endtask

  task automatic t_reset;
    chk("pll_control_reg_o", pll_control_reg_o, pmc_pkg::PLL_CONTROL_REG_RST);
    chk("regulator_control_reg_o", regulator_control_reg_o, pmc_pkg::REGULATOR_CONTROL_REG_RST);
    wait_mode(pmc_pkg::FULL_ON);
    chk_clk(5'h17);
    chk("pin_oe_o", 16'(pin_oe_o), 16'h00A5);
    $display("test reset done");
  endtask

  task automatic t_sleep_wake(input logic byp);
    req(pmc_pkg::REQ_SLEEP);
    wait_mode(pmc_pkg::SLEEP);
    chk("core_sys_pll", 16'({pll_en_o, core_clk_en_o, sys_clk_en_o}),
        16'h0005);
    chk("dma_l1_gnt_o", 16'(dma_l1_gnt_o), 16'h0000);
    wake_i = 1'b1;
    wait_mode(byp ? pmc_pkg::ACTIVE : pmc_pkg::FULL_ON);
    wake_i = 1'b0;
    cyc(4);
    $display("test sleep wake done");
  endtask

  task automatic t_active;
    wr(1'b0, 16'h0100);
    wait_mode(pmc_pkg::ACTIVE);
    chk_clk(5'h1F);
    chk("dma_l1_gnt_o", 16'(dma_l1_gnt_o), 16'h0001);
    dma_l1_cfg_ok_i = 1'b0;
    cyc();
    chk("dma_l1_gnt_o", 16'(dma_l1_gnt_o), 16'h0000);
    dma_l1_cfg_ok_i = 1'b1;
    t_sleep_wake(1'b1);
    wr(1'b0, 16'h0102);
    mode_req_i = pmc_pkg::REQ_SLEEP;
    cyc();
    chk("req_refused_o", 16'(req_refused_o), 16'h0001);
    chk_clk(5'h0F);
    chk("pll_control_reg_o", pll_control_reg_o, 16'h0102);
    mode_req_i = pmc_pkg::REQ_NONE;
    cyc(2);
    chk("mode_o", 16'(mode_o), 16'(pmc_pkg::ACTIVE));
    wr(1'b0, 16'h0000);
    req(pmc_pkg::REQ_FULL_ON);
    wait_mode(pmc_pkg::FULL_ON);
    $display("test active done");
  endtask

  task automatic t_deep;
    async_acc_req_i = 1'b1;
    req(pmc_pkg::REQ_DEEP_SLEEP);
    wait_mode(pmc_pkg::DEEP_SLEEP);
    chk("core_sys", 16'({core_clk_en_o, sys_clk_en_o}), 16'h0000);
    chk("async_acc_gnt_o", 16'(async_acc_gnt_o), 16'h0000);
    wake_i = 1'b1;
    cyc(6);
    chk("mode_o", 16'(mode_o), 16'(pmc_pkg::DEEP_SLEEP));
    wake_i = 1'b0;
    rtc_irq_i = 1'b1;
    wait_mode(pmc_pkg::ACTIVE);
    chk("async_acc_gnt_o", 16'(async_acc_gnt_o), 16'h0001);
    rtc_irq_i = 1'b0;
    cyc(4);
    req(pmc_pkg::REQ_FULL_ON);
    wait_mode(pmc_pkg::FULL_ON);
    req(pmc_pkg::REQ_DEEP_SLEEP);
    wait_mode(pmc_pkg::DEEP_SLEEP);
    reset_pin_i = 1'b1;
    wait_mode(pmc_pkg::FULL_ON);
    reset_pin_i = 1'b0;
    cyc(4);
    $display("test deep sleep done");
  endtask

  task automatic t_hib;
    logic [15:0] saved;
    saved = pll_control_reg_o;
    wr(1'b1, 16'h0000);
    wait_mode(pmc_pkg::HIBERNATE);
    chk("clock_reg", 16'({core_clk_en_o, sys_clk_en_o, regulator_on_o}),
        16'h0000);
    chk_clk(5'h00);
    chk("regulator_control_reg_o", regulator_control_reg_o, 16'h0000);
    chk("pin_oe_o", 16'(pin_oe_o), 16'h0005);
    rtc_irq_i = 1'b1;
    wait_mode(pmc_pkg::FULL_ON);
    rtc_irq_i = 1'b0;
    chk("regulator_on_o", 16'(regulator_on_o), 16'h0001);
    wr(1'b0, saved);
    chk("pll_control_reg_o", pll_control_reg_o, saved);
    cyc();
    wr(1'b1, 16'h0003);
    $display("test hibernate done");
  endtask

  initial begin
    #20000;
    error_cnt++;
    conclude();
  end

  initial begin
    {rst_b_i, reset_pin_i, rtc_irq_i, wake_i, pll_wr_i, vr_wr_i} = '0;
    {pll_wdata_i, vr_wdata_i} = '0;
    mode_req_i = pmc_pkg::REQ_NONE;
    {dma_l1_req_i, dma_l1_cfg_ok_i, async_acc_req_i} = 3'h6;
    pin_oe_i = 8'hA5;
    pin_keep_i = 8'h0F;
    repeat (5) @(posedge clk_sys_i);
    cyc();
    rst_b_i = 1'b1;
    t_reset();
    t_sleep_wake(1'b0);
    t_active();
    t_deep();
    t_hib();
    conclude();
  end
endmodule
